// >>> rtl/pws_pkg.sv
// Purpose: shared constants and types of the four-unit pwm timer block
// Assumes: 32-bit apb, registers 16 bits wide in the low half of each word
// Notes:   struct field order fixes the register bit layout
package pws_pkg;
  localparam int          NUM_UNITS  = 4;
  localparam logic [5:0]  UNIT_FIRST = 6'h05;
  localparam logic [4:0]  REG_CTRL   = 5'h00;
  localparam logic [4:0]  REG_PERIOD = 5'h04;
  localparam logic [4:0]  REG_WIDTH  = 5'h08;
  localparam logic [4:0]  REG_COUNT  = 5'h0C;
  localparam logic [7:0]  OFF_CONFIG = 8'h80;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h075F;
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [15:0] CFG_WMASK  = 16'hC00F;
  localparam logic [15:0] VAL_RESET  = 16'h0000;
  localparam logic [15:0] CNT_START  = 16'h0001;
  localparam logic [1:0]  FIRST_STAGE_PRESCALER_MAX2  = 2'h1;
  localparam logic [1:0]  FIRST_STAGE_PRESCALER_MAX3  = 2'h2;
  localparam logic [2:0]  CLK_SEL_TOP = 3'h7;
  localparam logic [7:0]  TAP_TOP    = 8'hFF;

  typedef struct packed {
    logic       flag;
    logic [3:0] rsv_hi;
    logic [2:0] irq_level;
    logic       rsv_lo;
    logic       arb_low;
    logic       load;
    logic       output_polarity_bit;
    logic       en;
    logic [2:0] clk_sel;
  } pws_ctrl_t;

  typedef struct packed {
    logic [1:0] vect_hi;
    logic [9:0] rsv;
    logic       div3;
    logic [2:0] arb_hi;
  } pws_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] arb;
    logic [7:0] vector;
  } pws_iack_rsp_t;
endpackage

// >>> rtl/pws_pwm_timer.sv
// Purpose: four pwm units with shared prescaler, apb registers, level irq and arbitration
// Assumes: single clock, apb slave with zero wait states
// Notes:   unit i sits at byte 32*i, config word at 0x80
`timescale 1ns/1ps

// Functional notes
// - output period equals selected divide ratio times active period value
// - prescaler fed by div2 or div3 stage, top tap divides by 256 more
// - shortest high pulse is one prescaled counter clock
// - longest non-steady pulse is one counter clock under the period
// - width zero keeps the output flop cleared
// - width at or above period keeps the output flop set
// - boundary cases hold a steady pin level chosen by polarity
// - period zero means 65536 clocks, widest pulse 65535
// - counter keeps counting during 0% and 100% duty
// - unused bits and locations read zero, writes ignored
// - four independent units, each with its own registers
// - each unit holds a 3-bit level and 1-bit arbitration value
// - level picks one of seven request lines, zero requests none
// - arbitration number is unit bit plus three shared config bits
// - lowest numbered requesting unit wins at the arbitrated level
// - vector is two config high bits then six bits of unit number
// - units are numbered 5 to 8
// - counter held at one when disabled, reloads to one on period match
// - width match clears output flop, counter untouched
// - next values copy to active at period start or on load write
// - flag sets at period start, request while flag and level nonzero
module pws_pwm_timer (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  output logic [3:0]                 pwm_out,
  output logic [7:1]                 irq_lines,
  input  wire logic                  iack_req,
  input  wire logic [2:0]            iack_level,
  output pws_pkg::pws_iack_rsp_t     iack_rsp
);
  localparam int N = pws_pkg::NUM_UNITS;

  function automatic logic [7:0] tap_mask(input logic [2:0] sel);
    logic [8:0] m;
    m = (9'h001 << sel) - 9'h001;
    tap_mask = (sel == pws_pkg::CLK_SEL_TOP) ? pws_pkg::TAP_TOP : m[7:0];
  endfunction

  function automatic logic [31:0] word16(input logic [15:0] v);
    word16 = {16'h0000, v};
  endfunction

  pws_pkg::pws_ctrl_t ctrl_q [N];
  pws_pkg::pws_cfg_t  cfg_q;
  logic [15:0]        nper_q [N];
  logic [15:0]        nwid_q [N];
  logic [15:0]        aper_q [N];
  logic [15:0]        awid_q [N];
  logic [15:0]        cnt_q  [N];
  logic [N-1:0]       ff_q;
  logic [N-1:0]       ff_d;
  logic [N-1:0]       tick;
  logic [N-1:0]       pstart;
  logic [N-1:0]       wend;
  logic [N-1:0]       req;
  logic [1:0]         first_stage_prescaler_q;
  logic [7:0]         psc_q;
  logic               pclk_tick;
  logic               setup;
  logic               commit;
  logic               in_unit;
  logic               cfg_hit;
  logic               mapped;
  logic [1:0]         unit;
  logic [4:0]         regoff;
  pws_pkg::pws_ctrl_t wr_ctrl;
  logic [N-1:0]       req_q;
  logic [2:0]         lvl_q  [N];

  // write strobe of one register of one unit, taken at the access edge
  function automatic logic unit_wr(input int idx, input logic [4:0] off);
    unit_wr = commit && in_unit && unit == 2'(idx) && regoff == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, so pready follows the access phase
  assign setup   = psel && !penable;
  assign pready  = psel && penable;
  assign commit  = psel && penable && pwrite;
  assign unit    = paddr[6:5];
  assign regoff  = paddr[4:0];
  assign in_unit = !paddr[7] && (regoff == pws_pkg::REG_CTRL || regoff == pws_pkg::REG_PERIOD ||
                   regoff == pws_pkg::REG_WIDTH || regoff == pws_pkg::REG_COUNT);
  assign cfg_hit = (paddr == pws_pkg::OFF_CONFIG);
  assign mapped  = in_unit || cfg_hit;
  assign wr_ctrl = pws_pkg::pws_ctrl_t'(pwdata[15:0]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      if (cfg_hit && !pwrite) begin
        prdata <= word16(cfg_q);
      end else if (in_unit && !pwrite) begin
        unique case (regoff)
          pws_pkg::REG_CTRL:   prdata <= word16(ctrl_q[unit]);
          pws_pkg::REG_PERIOD: prdata <= word16(nper_q[unit]);
          pws_pkg::REG_WIDTH:  prdata <= word16(nwid_q[unit]);
          default:             prdata <= word16(cnt_q[unit]);
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= pws_pkg::CFG_RESET;
    end else if (commit && cfg_hit) begin
      cfg_q <= pwdata[15:0] & pws_pkg::CFG_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared first stage and 8-bit prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_stage_prescaler_q <= 2'h0;
      psc_q  <= 8'h00;
    end else begin
      if (pclk_tick) begin
        first_stage_prescaler_q <= 2'h0;
        psc_q  <= psc_q + 8'h01;
      end else begin
        first_stage_prescaler_q <= first_stage_prescaler_q + 2'h1;
      end
    end
  end

  assign pclk_tick = (first_stage_prescaler_q == (cfg_q.div3 ? pws_pkg::FIRST_STAGE_PRESCALER_MAX3 : pws_pkg::FIRST_STAGE_PRESCALER_MAX2));

  ////////////////////////////////////////////////////////////////////////////
  // per-unit sequencing
  always_comb begin
    for (int i = 0; i < N; i++) begin
      tick[i]   = pclk_tick && ((psc_q & tap_mask(ctrl_q[i].clk_sel)) ==
                  tap_mask(ctrl_q[i].clk_sel));
      pstart[i] = ctrl_q[i].en && tick[i] && (cnt_q[i] == aper_q[i]);
      wend[i]   = ctrl_q[i].en && tick[i] && (cnt_q[i] == awid_q[i]);
      req[i]    = ctrl_q[i].flag && (ctrl_q[i].irq_level != 3'h0);
      if (!ctrl_q[i].en) begin
        ff_d[i] = 1'b0;
      end else if (awid_q[i] == 16'h0000) begin
        ff_d[i] = 1'b0;
      end else if (aper_q[i] != 16'h0000 && awid_q[i] >= aper_q[i]) begin
        ff_d[i] = 1'b1;
      end else if (pstart[i]) begin
        ff_d[i] = 1'b1;
      end else if (wend[i]) begin
        ff_d[i] = 1'b0;
      end else begin
        ff_d[i] = ff_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        cnt_q[i] <= pws_pkg::CNT_START;
      end
    end else begin
      // a period shrunk below the running count is only met after the wrap
      for (int i = 0; i < N; i++) begin
        if (!ctrl_q[i].en || pstart[i]) begin
          cnt_q[i] <= pws_pkg::CNT_START;
        end else if (tick[i]) begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  // the pin is taken after the polarity xor so a pol write cannot glitch it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ff_q    <= '0;
      pwm_out <= '0;
    end else begin
      ff_q <= ff_d;
      for (int i = 0; i < N; i++) begin
        pwm_out[i] <= ff_d[i] ^ ctrl_q[i].output_polarity_bit;
      end
    end
  end

  // a write landing on the period edge would tear the pair, so that copy waits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        nper_q[i] <= pws_pkg::VAL_RESET;
        nwid_q[i] <= pws_pkg::VAL_RESET;
        aper_q[i] <= pws_pkg::VAL_RESET;
        awid_q[i] <= pws_pkg::VAL_RESET;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (unit_wr(i, pws_pkg::REG_PERIOD)) begin
          nper_q[i] <= pwdata[15:0];
        end
        if (unit_wr(i, pws_pkg::REG_WIDTH)) begin
          nwid_q[i] <= pwdata[15:0];
        end
        if ((unit_wr(i, pws_pkg::REG_CTRL) && wr_ctrl.load) ||
            (pstart[i] && !unit_wr(i, pws_pkg::REG_PERIOD) &&
             !unit_wr(i, pws_pkg::REG_WIDTH))) begin
          aper_q[i] <= nper_q[i];
          awid_q[i] <= nwid_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        ctrl_q[i] <= pws_pkg::CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (unit_wr(i, pws_pkg::REG_CTRL)) begin
          ctrl_q[i] <= pwdata[15:0] & pws_pkg::CTRL_WMASK;
          // write one clears the flag, but a period start in the same cycle wins
          ctrl_q[i].flag <= pstart[i] || (ctrl_q[i].flag && !wr_ctrl.flag);
        end else if (pstart[i]) begin
          ctrl_q[i].flag <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request lines and arbitration among the units
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_lines <= '0;
    end else begin
      for (int l = 1; l < 8; l++) begin
        irq_lines[l] <= 1'b0;
        for (int i = 0; i < N; i++) begin
          if (req[i] && ctrl_q[i].irq_level == 3'(l)) begin
            irq_lines[l] <= 1'b1;
          end
        end
      end
    end
  end

  // the answer uses the same registered view that drives the lines, so no unit
  // can win on a level whose line was still low at the acknowledge edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= '0;
      for (int i = 0; i < N; i++) begin
        lvl_q[i] <= 3'h0;
      end
    end else begin
      req_q <= req;
      for (int i = 0; i < N; i++) begin
        lvl_q[i] <= ctrl_q[i].irq_level;
      end
    end
  end

  // scanning downward lets the lowest numbered pending unit overwrite the rest
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iack_rsp <= '0;
    end else begin
      iack_rsp.valid <= 1'b0;
      if (iack_req) begin
        for (int i = N - 1; i >= 0; i--) begin
          if (req_q[i] && lvl_q[i] == iack_level) begin
            iack_rsp.valid  <= 1'b1;
            iack_rsp.arb    <= {ctrl_q[i].arb_low, cfg_q.arb_hi};
            iack_rsp.vector <= {cfg_q.vect_hi, pws_pkg::UNIT_FIRST + 6'(i)};
          end
        end
      end
    end
  end
endmodule

// >>> verification/pws_pwm_timer_props.sv
// Purpose: port checker for pws_pwm_timer
// Assumes: zero-wait apb, acknowledge answered one edge after the request
// Notes:   attached to every pws_pwm_timer by the bind at the foot
`timescale 1ns/1ps
module pws_props (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [31:0]            prdata,
  input wire logic [7:1]             irq_lines,
  input wire logic                   iack_req,
  input wire logic [2:0]             iack_level,
  input wire pws_pkg::pws_iack_rsp_t iack_rsp
);
  logic [7:0] lines_sh;
  logic       ask;
  // bit 0 of the shifted vector is the line at the arbitrated level; level 0 hits nothing
  assign lines_sh = {irq_lines, 1'b0} >> iack_level;
  assign ask      = iack_req && lines_sh[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_ask; ask; endsequence
  sequence s_win; iack_rsp.valid; endsequence
  property p_ready; pready == (psel && penable); endproperty
  a_ready: assert property (p_ready) else $error("pready not equal to access phase");
  property p_hi_zero; prdata[31:16] == 16'h0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  property p_win; s_ask |=> s_win; endproperty
  a_win: assert property (p_win) else $error("pending level not answered");
  property p_cause; s_win |-> $past(ask); endproperty
  a_cause: assert property (p_cause) else $error("answer without pending level");
  property p_lvl0; iack_req && iack_level == 3'h0 |=> !iack_rsp.valid; endproperty
  a_lvl0: assert property (p_lvl0) else $error("answer at level zero");
  property p_vec; s_win |-> iack_rsp.vector[5:0] inside {[6'h05:6'h08]}; endproperty
  a_vec: assert property (p_vec) else $error("vector outside unit numbers");
  property p_hold; !iack_rsp.valid |-> $stable(iack_rsp.vector); endproperty
  a_hold: assert property (p_hold) else $error("vector moved without a win");
endmodule

bind pws_pwm_timer pws_props u_props (
  .clk, .reset_n, .psel, .penable, .pready, .pslverr, .prdata,
  .irq_lines, .iack_req, .iack_level, .iack_rsp
);

// >>> verification/pws_host_model.sv
// Purpose: host processor model, apb master and interrupt acknowledge
// Assumes: one transfer at a time, 16-bit values in the low half
// Notes:   a stalled bus ends the run through the bench's closing task
`timescale 1ns/1ps
module pws_host_model (
  input  wire logic                   clk,
  input  wire logic                   pready,
  input  wire logic [31:0]            prdata,
  input  wire logic                   pslverr,
  input  wire pws_pkg::pws_iack_rsp_t iack_rsp,
  output logic                        psel,
  output logic                        penable,
  output logic                        pwrite,
  output logic [7:0]                  paddr,
  output logic [31:0]                 pwdata,
  output logic                        iack_req,
  output logic [2:0]                  iack_level
);
  initial {psel, penable, pwrite, paddr, pwdata, iack_req, iack_level} = '0;
  // system clock and wanted output frequency both in khz
  function automatic logic [15:0] per_for(int ratio, int f_khz);
    return 16'(200000 / (ratio * f_khz));
  endfunction
  function automatic logic [15:0] wid_for(int duty, int per);
    return 16'(duty * per / 100);
  endfunction
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      pws_pwm_timer_test.fail_count++;
      pws_pwm_timer_test.complete_run();
    end
    q   = prdata[15:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ack(input logic [2:0] lvl, output pws_pkg::pws_iack_rsp_t r);
    @(posedge clk);
    iack_req   <= 1'b1;
    iack_level <= lvl;
    @(posedge clk);
    iack_req <= 1'b0;
    @(posedge clk);
    r = iack_rsp;
  endtask
endmodule

// >>> verification/pws_pwm_timer_test.sv
// Purpose: self-checking bench of pws_pwm_timer
// Assumes: 200 MHz clock, host model drives apb and acknowledge
// Notes:   unit 0 carries the waveform checks, units 0 and 1 the interrupts
`timescale 1ns/1ps
module pws_pwm_timer_test;
  logic                   clk;
  logic                   reset_n;
  logic                   psel, penable, pwrite, pready, pslverr, iack_req;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata;
  logic [3:0]             pwm_out;
  logic [7:1]             irq_lines;
  logic [2:0]             iack_level;
  pws_pkg::pws_iack_rsp_t iack_rsp;
  int                     fail_count = 0;
  int                     total_checks = 0;

  pws_pwm_timer uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pwm_out, .irq_lines, .iack_req, .iack_level, .iack_rsp);
  pws_host_model host (.clk, .pready, .prdata, .pslverr, .iack_rsp, .psel, .penable,
    .pwrite, .paddr, .pwdata, .iack_req, .iack_level);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run();
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp, input logic eexp);
    logic [15:0] q;
    logic        e;
    host.xfer(1'b0, a, 16'h0000, q, e);
    check({15'h0, e, q}, {15'h0, eexp, exp});
  endtask
  // a steady pin never rises, so every loop is bounded and a hang fails the run
  task meas(output int hi, output int per);
    int n;
    for (n = 0; n < 3000 && pwm_out[0] !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 3000 && pwm_out[0] !== 1'b1; n++) @(posedge clk);
    if (n == 3000) begin
      fail_count++;
      complete_run();
    end
    for (hi = 0; hi < 3000 && pwm_out[0] === 1'b1; hi++) @(posedge clk);
    for (per = hi; per < 3000 && pwm_out[0] === 1'b0; per++) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs();
    rd(8'h00, pws_pkg::CTRL_RESET, 1'b0);
    rd(8'h2C, pws_pkg::CNT_START, 1'b0);
    wr(8'h2C, 16'h1234);
    rd(8'h2C, pws_pkg::CNT_START, 1'b0);
    rd(8'h10, 16'h0000, 1'b1);
    wr(8'h60, 16'hFFFF);
    rd(8'h60, pws_pkg::CTRL_WMASK, 1'b0);
    check(32'(pwm_out), 32'h8);
    wr(8'h60, 16'h0000);
  endtask
  task run_freq(input logic [15:0] cfg, input logic [2:0] sel, input int pv, input int wv);
    int r, hi, per;
    r = (cfg[3] ? 3 : 2) * (sel == 3'h7 ? 256 : (1 << sel));
    // a disabled counter sits at one, so a shorter new period is met at once
    wr(8'h00, 16'h0000);
    wr(8'h80, cfg);
    wr(8'h04, 16'(pv));
    wr(8'h08, 16'(wv));
    wr(8'h00, {10'h000, 3'b101, sel});
    meas(hi, per);
    check(32'(hi), 32'(r * wv));
    check(32'(per), 32'(r * pv));
  endtask
  task t_freq();
    run_freq(16'h0000, 3'h0, host.per_for(2, 25000), host.wid_for(25, 4));
    run_freq(16'h0000, 3'h0, 4, 3);
    run_freq(16'h0008, 3'h1, 4, 3);
    run_freq(16'h0000, 3'h7, 2, 1);
    run_freq(16'h0008, 3'h2, 5, 2);
  endtask
  task run_edge(input logic [15:0] wv, input logic output_polarity_bit, input logic lvl);
    int          n, bad;
    logic [15:0] c1, c2;
    logic        e;
    wr(8'h08, wv);
    wr(8'h00, {10'h000, 1'b1, output_polarity_bit, 1'b1, 3'h0});
    repeat (20) @(posedge clk);
    bad = 0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (pwm_out[0] !== lvl) bad++;
    end
    check(32'(bad), 32'h0);
    host.xfer(1'b0, 8'h0C, 16'h0000, c1, e);
    host.xfer(1'b0, 8'h0C, 16'h0000, c2, e);
    check({31'h0, c1 !== c2}, 32'h1);
  endtask
  task t_edge();
    wr(8'h80, 16'h0000);
    wr(8'h04, 16'h0004);
    run_edge(16'h0000, 1'b0, 1'b0);
    run_edge(16'h0000, 1'b1, 1'b1);
    run_edge(16'h0005, 1'b0, 1'b1);
    run_edge(16'h0005, 1'b1, 1'b0);
  endtask
  task t_irq();
    pws_pkg::pws_iack_rsp_t r;
    wr(8'h80, 16'h8005);
    wr(8'h24, 16'h0004);
    wr(8'h28, 16'h0001);
    wr(8'h20, 16'h0368);
    wr(8'h00, 16'h0348);
    repeat (20) @(posedge clk);
    check(32'(irq_lines), 32'h4);
    host.ack(3'h3, r);
    check(32'(r), 32'h1D85);
    host.ack(3'h0, r);
    check(32'(r.valid), 32'h0);
    host.ack(3'h2, r);
    check(32'(r.valid), 32'h0);
    wr(8'h00, 16'h8008);
    host.ack(3'h3, r);
    check(32'(r), 32'h1D86);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_freq();
    t_edge();
    t_irq();
    complete_run();
  end
endmodule
